// ---- mpf_regs.svh ----
// register indices, field positions, reset values and timing counts for pause flow control
`ifndef MPF_REGS_SVH
`define MPF_REGS_SVH

// register indices; byte address is four times the index
`define MPF_IDX_CTRL 12'h700
`define MPF_IDX_SW_REQ 12'h701
`define MPF_IDX_CLASS_EN 12'h702
`define MPF_IDX_Q_SEL 12'h703
`define MPF_IDX_Q_VAL 12'h704
`define MPF_IDX_HOLDOFF 12'h705
`define MPF_IDX_STATUS 12'h706
`define MPF_IDX_ADDR_LOW 12'h707
`define MPF_IDX_ADDR_HIGH 12'h708

// control register fields
`define MPF_CTRL_PROC_EN 0
`define MPF_CTRL_FWD 1
`define MPF_CTRL_HONOR 2
`define MPF_CTRL_RETX 3

// reset values
`define MPF_RST_PROC_EN 1'b1
`define MPF_RST_FWD 1'b0
`define MPF_RST_HONOR 1'b1
`define MPF_RST_RETX 1'b0
`define MPF_RST_CLASS_EN 8'hFF
`define MPF_RST_ADDR_LOW 32'hC28001
`define MPF_RST_ADDR_HIGH 16'h0100

// frame constants
`define MPF_PAUSE_DA 48'h010000C28001
`define MPF_PAUSE_TYPE 16'h8808
`define MPF_OP_STD 16'h0001
`define MPF_OP_PRIO 16'h0101
`define MPF_XON_QUANTA 16'h0000

// one quantum is 512 bit times at the link rate
`define MPF_QUANTUM_BITS 512
`define MPF_LINK_GBPS 100
`define MPF_QUANTUM_PS (`MPF_QUANTUM_BITS * 1000 / `MPF_LINK_GBPS)
`define MPF_CLK_PS 25000
`define MPF_QUANTUM_CLKS ((`MPF_QUANTUM_PS + `MPF_CLK_PS - 1) / `MPF_CLK_PS)

`endif

// ---- mpf_pkg.sv ----
// types shared by the pause flow control block
package mpf_pkg;

  typedef enum logic [0:0] {
    MPF_TX_IDLE,
    MPF_TX_SEND
  } mpf_tx_state_t;

  typedef struct packed {
    mpf_tx_state_t tx_st;
    logic proc_en;
    logic fwd;
    logic honor;
    logic retx;
    logic [7:0] sw_req;
    logic [7:0] class_en;
    logic [2:0] q_sel;
    logic [7:0][15:0] quanta;
    logic [15:0] holdoff;
    logic [31:0] addr_low;
    logic [15:0] addr_high;
    logic [7:0] req_q;
    logic [7:0] xoff_pend;
    logic [7:0] xon_pend;
    logic hold_run;
    logic [15:0] hold_cnt;
    logic [7:0] pre;
    logic [7:0][15:0] tmr;
    logic [7:0] match;
    logic suspend;
    logic [31:0] prdata;
    logic pslverr;
    logic pf_valid;
    logic pf_xoff;
    logic [15:0] pf_opcode;
    logic [15:0] pf_prio_en;
    logic [7:0][15:0] pf_time;
    logic rx_verdict;
    logic rx_drop;
  } mpf_state_t;

endpackage : mpf_pkg

// ---- mpf_flow_ctrl.sv ----
// pause frame generation, reception filtering and pause timing with apb registers
//
// Our own choice: register access over APB.
`include "mpf_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mpf_flow_ctrl
  import mpf_pkg::*;
#(
  parameter int N_CLASS = 1,
  parameter bit PRIO_MODE = 1'b0,
  parameter bit RUNT_FILTER = 1'b1,
  parameter int QUANTUM_CLKS = `MPF_QUANTUM_CLKS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_CLASS-1:0] client_pause_request,
  input wire logic tx_frame_busy,
  output logic pf_valid,
  input wire logic pf_ready,
  output logic pf_xoff,
  output logic [47:0] pf_dest,
  output logic [15:0] pf_type,
  output logic [15:0] pf_opcode,
  output logic [15:0] pf_prio_en,
  output logic [127:0] pf_time,
  input wire logic rx_hdr_valid,
  input wire logic [47:0] rx_dest,
  input wire logic [15:0] rx_type,
  input wire logic [15:0] rx_opcode,
  input wire logic rx_len_ok,
  input wire logic rx_runt,
  input wire logic rx_fcs_err,
  input wire logic [15:0] rx_prio_en,
  input wire logic [127:0] rx_time,
  output logic rx_verdict_valid,
  output logic rx_drop,
  output logic [N_CLASS-1:0] rx_pause_match,
  output logic tx_pause_suspend
);

  // quantum length rounds up so a pause never runs short; at the default
  // clock a quantum is under one cycle, so every cycle is a tick
  localparam logic [7:0] QCLK = 8'(QUANTUM_CLKS);
  localparam logic [7:0] CMASK = 8'((9'h001 << N_CLASS) - 9'h001);

  mpf_state_t r;
  mpf_state_t n;

  logic [7:0] cli;
  logic [7:0] eff;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [11:0] idx;
  logic wr;
  logic setup;
  logic tick;
  logic is_pause;
  logic addr_hit;
  logic act;
  logic bad;
  logic [7:0] take;
  logic launched;
  logic [7:0] sent_xoff;
  logic [7:0] sent_xon;
  logic type_hit;
  logic op_hit;

  always_comb
  begin
    n = r;
    cli = 8'h00;
    cli[N_CLASS-1:0] = client_pause_request;
    idx = paddr[13:2];
    wr = psel && penable && pwrite;
    setup = psel && !penable;
    tick = (r.pre == QCLK - 8'h01);
    take = 8'h00;

    // register writes take effect in the access phase
    if (wr)
    begin
      unique case (idx)
        `MPF_IDX_CTRL:
        begin
          n.proc_en = pwdata[`MPF_CTRL_PROC_EN];
          n.fwd = pwdata[`MPF_CTRL_FWD];
          n.honor = pwdata[`MPF_CTRL_HONOR];
          n.retx = pwdata[`MPF_CTRL_RETX];
        end
        `MPF_IDX_SW_REQ:
        begin
          n.sw_req = pwdata[7:0] & CMASK;
        end
        `MPF_IDX_CLASS_EN:
        begin
          n.class_en = pwdata[7:0] & CMASK;
        end
        `MPF_IDX_Q_SEL:
        begin
          n.q_sel = pwdata[2:0];
        end
        // value stored under the selected class
        `MPF_IDX_Q_VAL:
        begin
          n.quanta[r.q_sel] = pwdata[15:0];
        end
        `MPF_IDX_HOLDOFF:
        begin
          n.holdoff = pwdata[15:0];
        end
        `MPF_IDX_ADDR_LOW:
        begin
          n.addr_low = pwdata;
        end
        `MPF_IDX_ADDR_HIGH:
        begin
          n.addr_high = pwdata[15:0];
        end
        // status is read-only: a write there is ignored without an error
        default: ;
      endcase
    end

    // read data and error latched in the setup phase so they come from flops
    if (setup)
    begin
      n.pslverr = 1'b0;
      unique case (idx)
        `MPF_IDX_CTRL: n.prdata = {28'h0, r.retx, r.honor, r.fwd, r.proc_en};
        `MPF_IDX_SW_REQ: n.prdata = {24'h0, r.sw_req};
        `MPF_IDX_CLASS_EN: n.prdata = {24'h0, r.class_en & CMASK};
        `MPF_IDX_Q_SEL: n.prdata = {29'h0, r.q_sel};
        `MPF_IDX_Q_VAL: n.prdata = {16'h0, r.quanta[r.q_sel]};
        `MPF_IDX_HOLDOFF: n.prdata = {16'h0, r.holdoff};
        `MPF_IDX_STATUS: n.prdata = {14'h0, r.suspend, r.pf_valid, r.match, r.req_q};
        `MPF_IDX_ADDR_LOW: n.prdata = r.addr_low;
        `MPF_IDX_ADDR_HIGH: n.prdata = {16'h0, r.addr_high};
        default:
        begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end

    n.pre = tick ? 8'h00 : r.pre + 8'h01;

    // software register and client line are ored into one level
    eff = (cli | r.sw_req) & CMASK;
    // history holds the combined level, so a second source adds no edge
    n.req_q = eff;
    // xoff on a fresh rise of an enabled class, or again at hold-off end while retx is set
    rise = eff & ~r.req_q & r.class_en;
    fall = ~eff & r.req_q & r.class_en;
    // a level already high raises no new edge, so no extra xoff except the retx resend after hold-off

    // hold-off timer restarts from each sent xoff and ends after exactly
    // the programmed quanta; a load of zero still waits one quantum
    if (r.hold_run && tick)
    begin
      if (r.hold_cnt <= 16'h0001)
      begin
        n.hold_run = 1'b0;
        n.hold_cnt = 16'h0000;
        // persisting request resends xoff after hold-off
        if (r.retx)
        begin
          rise = rise | (eff & r.class_en);
        end
      end
      else
      begin
        n.hold_cnt = r.hold_cnt - 16'h0001;
      end
    end

    // frame launch waits for the current frame to finish
    unique case (r.tx_st)
      MPF_TX_IDLE:
      begin
        // xoff beats xon so a congested receiver is protected first
        if (((r.xoff_pend | r.xon_pend) != 8'h00) && !tx_frame_busy)
        begin
          n.tx_st = MPF_TX_SEND;
          n.pf_valid = 1'b1;
          n.pf_xoff = (r.xoff_pend != 8'h00);
          take = n.pf_xoff ? r.xoff_pend : r.xon_pend;
          n.pf_time = '0;
          n.pf_prio_en = PRIO_MODE ? {8'h00, take} : 16'h0000;
          // opcode by mode; xon time fields stay zero
          n.pf_opcode = PRIO_MODE ? `MPF_OP_PRIO : `MPF_OP_STD;
          if (n.pf_xoff)
          begin
            for (int i = 0; i < 8; i++)
            begin
              // time field n carries quanta of class n
              if (take[i])
              begin
                n.pf_time[i] = r.quanta[i];
              end
            end
          end
          else
          begin
            n.pf_time[0] = `MPF_XON_QUANTA;
          end
        end
      end
      MPF_TX_SEND:
      begin
        if (pf_ready)
        begin
          n.tx_st = MPF_TX_IDLE;
          n.pf_valid = 1'b0;
          // hold-off starts only once the xoff has really left
          if (r.pf_xoff)
          begin
            n.hold_run = 1'b1;
            n.hold_cnt = r.holdoff;
          end
        end
      end
    endcase

    // bits taken by the frame launched this cycle leave their pending set
    launched = (r.tx_st == MPF_TX_IDLE) && n.pf_valid;
    sent_xoff = (launched && n.pf_xoff) ? take : 8'h00;
    sent_xon = (launched && !n.pf_xoff) ? take : 8'h00;
    // newest edge wins and cancels the opposite frame still waiting, so the
    // last frame on the link matches the final request level as long as the class stays set in class_en
    for (int i = 0; i < 8; i++)
    begin
      if (rise[i])
      begin
        n.xoff_pend[i] = 1'b1;
        n.xon_pend[i] = 1'b0;
      end
      else if (fall[i])
      begin
        n.xoff_pend[i] = 1'b0;
        n.xon_pend[i] = 1'b1;
      end
      else
      begin
        n.xoff_pend[i] = r.xoff_pend[i] && !sent_xoff[i];
        n.xon_pend[i] = r.xon_pend[i] && !sent_xon[i];
      end
    end

    // pause recognised by length, type and the opcode of this mode
    type_hit = (rx_type == `MPF_PAUSE_TYPE);
    op_hit = (rx_opcode == (PRIO_MODE ? `MPF_OP_PRIO : `MPF_OP_STD));
    is_pause = rx_len_ok && type_hit && op_hit;
    // reserved multicast or the configured 48-bit address
    addr_hit = (rx_dest == `MPF_PAUSE_DA) || (rx_dest == {r.addr_high, r.addr_low});
    bad = rx_runt || rx_fcs_err;
    // processing gate and, in standard mode only, runt or fcs filter
    act = rx_hdr_valid && is_pause && addr_hit && r.proc_en
      && !(RUNT_FILTER && !PRIO_MODE && bad);
    n.rx_verdict = rx_hdr_valid;
    // drop matches unless forwarding and processing are on
    n.rx_drop = rx_hdr_valid && is_pause && addr_hit && (!r.proc_en || !r.fwd);

    for (int i = 0; i < 8; i++)
    begin
      if (tick && (r.tmr[i] != 16'h0000))
      begin
        n.tmr[i] = r.tmr[i] - 16'h0001;
      end
      // newest quanta overrides the running count
      // a decrement in the same cycle loses to the received value
      if (act && (i < N_CLASS))
      begin
        if (!PRIO_MODE && (i == 0))
        begin
          n.tmr[i] = rx_time[15:0];
        end
        else if (PRIO_MODE && rx_prio_en[i])
        begin
          n.tmr[i] = rx_time[16*i +: 16];
        end
      end
      // match bit held while class is paused
      n.match[i] = (n.tmr[i] != 16'h0000) && (i < N_CLASS);
    end

    n.suspend = PRIO_MODE ? (n.match != 8'h00) : (n.match[0] && r.honor);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.tx_st <= MPF_TX_IDLE;
      r.proc_en <= `MPF_RST_PROC_EN;
      r.fwd <= `MPF_RST_FWD;
      r.honor <= `MPF_RST_HONOR;
      r.retx <= `MPF_RST_RETX;
      r.class_en <= `MPF_RST_CLASS_EN;
      r.addr_low <= `MPF_RST_ADDR_LOW;
      r.addr_high <= `MPF_RST_ADDR_HIGH;
    end
    else
    begin
      r <= n;
    end
  end

  // zero-wait slave: access phase always completes in one cycle
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign pf_valid = r.pf_valid;
  assign pf_xoff = r.pf_xoff;
  // header constants are wired, not stored
  assign pf_dest = `MPF_PAUSE_DA;
  assign pf_type = `MPF_PAUSE_TYPE;
  assign pf_opcode = r.pf_opcode;
  assign pf_prio_en = r.pf_prio_en;
  assign pf_time = r.pf_time;
  assign rx_verdict_valid = r.rx_verdict;
  assign rx_drop = r.rx_drop;
  assign rx_pause_match = r.match[N_CLASS-1:0];
  assign tx_pause_suspend = r.suspend;

endmodule : mpf_flow_ctrl

`default_nettype wire

// ---- mpf_chk.sv ----
// port assertions for the pause flow control block
`timescale 1ns/1ps
`default_nettype none
module mpf_chk
#(
  parameter int N_CLASS = 1,
  parameter bit PRIO_MODE = 1'b0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N_CLASS-1:0] client_pause_request,
  input wire logic tx_frame_busy,
  input wire logic pf_valid,
  input wire logic pf_ready,
  input wire logic pf_xoff,
  input wire logic [47:0] pf_dest,
  input wire logic [15:0] pf_type,
  input wire logic [15:0] pf_opcode,
  input wire logic [127:0] pf_time,
  input wire logic rx_hdr_valid,
  input wire logic [15:0] rx_type,
  input wire logic rx_verdict_valid,
  input wire logic rx_drop,
  input wire logic [N_CLASS-1:0] rx_pause_match,
  input wire logic tx_pause_suspend
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_rise;
    $rose(client_pause_request[0]);
  endsequence
  sequence s_fall;
    $fell(client_pause_request[0]);
  endsequence
  xoff_after_rise_a: assert property (s_rise |-> ##[1:60] (pf_valid && pf_xoff))
    else $error("no xoff after request rose");
  xon_after_fall_a: assert property (s_fall |-> ##[1:60] (pf_valid && !pf_xoff))
    else $error("no xon after request fell");
  frame_hold_a: assert property (pf_valid && !pf_ready |=>
    pf_valid && $stable(pf_xoff) && $stable(pf_time)) else $error("frame changed early");
  frame_gap_a: assert property (pf_valid && pf_ready |=> !pf_valid)
    else $error("request kept after accept");
  launch_idle_a: assert property ($rose(pf_valid) |-> !$past(tx_frame_busy))
    else $error("frame launched during busy");
  frame_const_a: assert property (pf_dest == 48'h010000C28001 && pf_type == 16'h8808)
    else $error("header constant wrong");
  opcode_a: assert property (pf_valid |->
    pf_opcode == (PRIO_MODE ? 16'h0101 : 16'h0001)) else $error("opcode wrong");
  xon_zero_a: assert property (pf_valid && !pf_xoff |-> pf_time == '0)
    else $error("xon time not zero");
  verdict_a: assert property (rx_verdict_valid == $past(rx_hdr_valid))
    else $error("verdict timing wrong");
  fwd_other_a: assert property (rx_hdr_valid && rx_type != 16'h8808 |=> !rx_drop)
    else $error("non pause frame dropped");
  suspend_match_a: assert property (tx_pause_suspend |-> |rx_pause_match)
    else $error("suspend without match");
endmodule : mpf_chk
bind mpf_flow_ctrl mpf_chk #(.N_CLASS(N_CLASS), .PRIO_MODE(PRIO_MODE)) mpf_chk_inst (
  .pclk, .presetn, .client_pause_request, .tx_frame_busy, .pf_valid, .pf_ready, .pf_xoff,
  .pf_dest, .pf_type, .pf_opcode, .pf_time, .rx_hdr_valid, .rx_type, .rx_verdict_valid,
  .rx_drop, .rx_pause_match, .tx_pause_suspend);
`default_nettype wire

// ---- mpf_mac_model.sv ----
// transmit mac stand-in: frame in flight and pause frame acceptance
`timescale 1ns/1ps
`default_nettype none
module mpf_mac_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic start_frame,
  output logic pf_ready,
  output logic tx_frame_busy
);
  int busy_cnt;
  int tick;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_cnt <= 0;
      tick <= 0;
    end
    else
    begin
      tick <= tick + 1;
      if (start_frame)
        busy_cnt <= 6;
      else if (busy_cnt != 0)
        busy_cnt <= busy_cnt - 1;
    end
  end
  // slow mode stalls: accept only every fourth cycle
  assign pf_ready = !slow || (tick % 4 == 3);
  assign tx_frame_busy = busy_cnt != 0;
endmodule : mpf_mac_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the pause flow control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic pready, pslverr, pf_valid, pf_ready, pf_xoff, vd, dr, mt, sp, busy;
  logic client = 0, slow = 0, start = 0, hdr = 0, runt = 0;
  logic [15:0] paddr = '0, rtype = '0, qv, pe, op;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'hC1694F38, own;
  logic [47:0] rdest = '0;
  logic [127:0] pf_time, rtime = '0;
  logic [15:0] tab [9] = '{16'h5007, 16'h7003, 16'h1006, 16'h4004, 16'h5107,
    16'h5200, 16'h5010, 16'h5024, 16'h7020};
  int error_cnt = 0, check_count = 0, n_fr = 0, lvl = 0;
  always #12.5 pclk = ~pclk;
  mpf_flow_ctrl mpf_flow_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .client_pause_request(client),
    .tx_frame_busy(busy), .pf_valid, .pf_ready, .pf_xoff, .pf_dest(), .pf_type(),
    .pf_opcode(op), .pf_prio_en(pe), .pf_time, .rx_hdr_valid(hdr), .rx_dest(rdest),
    .rx_type(rtype), .rx_opcode(16'h0001), .rx_len_ok(1'b1), .rx_runt(runt),
    .rx_fcs_err(1'b0), .rx_prio_en(16'h0000), .rx_time(rtime), .rx_verdict_valid(vd),
    .rx_drop(dr), .rx_pause_match(mt), .tx_pause_suspend(sp));
  mpf_mac_model mpf_mac_model_inst (.pclk, .presetn, .slow, .start_frame(start), .pf_ready,
    .tx_frame_busy(busy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (k == 20)
    begin
      error_cnt++;
      end_sim();
    end
  endtask : apb
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input logic e);
    apb(0, idx, 0);
    chk(rd, exp);
    chk(er, e);
  endtask : rdchk
  task automatic wait_fr(input int n);
    int k;
    k = 0;
    while (n_fr < n && k < 200)
    begin
      @(posedge pclk);
      k++;
    end
    chk(n_fr, n);
    if (k == 200)
      end_sim();
  endtask : wait_fr
  task automatic rx(input logic [47:0] d, input logic [15:0] t, input logic r,
    input logic [15:0] tm);
    rdest <= d;
    rtype <= t;
    runt <= r;
    rtime <= {112'h0, tm};
    hdr <= 1;
    @(posedge pclk);
    hdr <= 0;
    #1;
  endtask : rx
  always @(posedge pclk)
    if (presetn && pf_valid && pf_ready)
    begin
      n_fr++;
      chk(pf_xoff, lvl != 0);
      chk(pf_time, lvl != 0 ? {112'h0, qv} : '0);
      chk(op, 16'h0001);
      chk(pe, 16'h0000);
    end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdchk(12'h700, 32'h5, 0);
    rdchk(12'h707, 32'hC28001, 0);
    rdchk(12'h709, 0, 1);
    own = rnd();
    qv = 16'(rnd());
    apb(1, 12'h707, own);
    apb(1, 12'h708, 32'hFFFF0A0B);
    apb(1, 12'h706, 32'hFFFF);
    apb(1, 12'h703, 0);
    apb(1, 12'h704, {16'h0, qv});
    rdchk(12'h707, own, 0);
    rdchk(12'h708, 32'hA0B, 0);
    rdchk(12'h706, 0, 0);
    rdchk(12'h704, {16'h0, qv}, 0);
    $display("register test done");
    for (int m = 0; m < 4; m++)
    begin
      slow <= m[0];
      n_fr = 0;
      start <= 1;
      @(posedge pclk);
      start <= 0;
      lvl <= 1;
      if (m[1])
        apb(1, 12'h701, 1);
      else
        client <= 1;
      wait_fr(1);
      repeat (20) @(posedge pclk);
      chk(n_fr, 1);
      lvl <= 0;
      if (m[1])
        apb(1, 12'h701, 0);
      else
        client <= 0;
      wait_fr(2);
    end
    slow <= 0;
    n_fr = 0;
    apb(1, 12'h702, 0);
    apb(1, 12'h701, 1);
    apb(1, 12'h701, 0);
    repeat (10) @(posedge pclk);
    chk(n_fr, 0);
    apb(1, 12'h702, 1);
    $display("generation test done");
    apb(1, 12'h705, 5);
    apb(1, 12'h700, 32'hD);
    lvl <= 1;
    client <= 1;
    repeat (60) @(posedge pclk);
    apb(1, 12'h700, 5);
    repeat (20) @(posedge pclk);
    chk(n_fr > 3 && n_fr < 13, 1);
    lvl <= 0;
    client <= 0;
    wait_fr(n_fr + 1);
    $display("retransmit test done");
    for (int i = 0; i < 9; i++)
    begin
      apb(1, 12'h700, {28'h0, tab[i][15:12]});
      rx(tab[i][9:8] == 0 ? 48'h010000C28001 : {tab[i][9] ? 16'h0B0C : 16'h0A0B, own},
        tab[i][4] ? 16'h0800 : 16'h8808, tab[i][5], 16'h0100);
      chk({vd, dr, mt, sp}, {1'b1, tab[i][2:0]});
      @(posedge pclk);
      apb(1, 12'h700, 5);
      rx(48'h010000C28001, 16'h8808, 0, 0);
      chk(mt, 0);
      @(posedge pclk);
    end
    $display("receive test done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
